// file: adcpf_defines.svh
// register map, field positions and timing counts of the converter control
// assumes a 50 MHz system clock and a word-aligned byte-addressed bus
`ifndef ADCPF_DEFINES_SVH
`define ADCPF_DEFINES_SVH

// byte offsets
`define ADCPF_OFS_MODE 5'h00
`define ADCPF_OFS_CHSEL 5'h04
`define ADCPF_OFS_RESULT 5'h08
`define ADCPF_OFS_PFMODE 5'h0c
`define ADCPF_OFS_PFTHR 5'h10
`define ADCPF_OFS_STATUS 5'h14

// mode register fields
`define ADCPF_MODE_EN_BIT 7
`define ADCPF_MODE_SEL_HI 5
`define ADCPF_MODE_SEL_LO 3
`define ADCPF_MODE_CMP_BIT 0
// power-fail mode fields
`define ADCPF_PFM_EN_BIT 7
`define ADCPF_PFM_LT_BIT 6
// status fields
`define ADCPF_ST_BUSY_BIT 0
`define ADCPF_ST_PEND_BIT 1
`define ADCPF_ST_HIT_BIT 2

// reset values
`define ADCPF_RST_BYTE 8'h00
`define ADCPF_RST_CHSEL 2'h0
`define ADCPF_RST_RESULT 10'h000

// timing, ns and derived cycles
`define ADCPF_CLK_NS 20
`define ADCPF_CYC(ns) (((ns) + `ADCPF_CLK_NS - 1) / `ADCPF_CLK_NS)
`define ADCPF_START_DLY_NS 1000
`define ADCPF_CONV_NS_0 14000
`define ADCPF_CONV_NS_1 18000
`define ADCPF_CONV_NS_2 24000
`define ADCPF_CONV_NS_3 28000
`define ADCPF_CONV_NS_4 36000
`define ADCPF_CONV_NS_5 48000
`define ADCPF_CONV_NS_6 56000
`define ADCPF_CONV_NS_7 72000

`endif

// file: adcpf_pkg.sv
// types shared by the converter control
// assumes nothing beyond a SystemVerilog compiler
package adcpf_pkg;
  typedef enum logic [1:0] {
    ADCPF_IDLE,
    ADCPF_START,
    ADCPF_CONV
  } adcpf_state_t;
endpackage

// file: adcpf_ctrl.sv
// converter control with power-fail compare, Avalon-MM slave with waitrequest
// assumes the analog core presents its result on adc_data_in at conversion end
//
// Function
// RULE_01: software halts conversion before changing the conversion time select
// RULE_02: mode register write gets one extra bus wait cycle
// RULE_03: software writes zero to channel-select bits 2 to 7
// RULE_04: channel-select write gets one extra bus wait cycle
// RULE_05: mode or channel write may leave the result undefined
// RULE_06: software reads the result before writing mode or channel-select
// RULE_07: result read gets one extra bus wait cycle
// RULE_08: power-fail mode write gets one extra bus wait cycle
// RULE_09: power-fail threshold write gets one extra bus wait cycle
// RULE_10: software waits 14 us from comparator power-on to enable
// RULE_11: comparator power-on and channel setup may come in either order
// RULE_12: skipping comparator power-on means discarding the first result
// RULE_13: conversion start to end equals the selected conversion time
// RULE_14: power-fail setup waits 14 us before enabling the converter
// RULE_15: power-fail setup steps three to five may come in any order
// RULE_16: power-fail use always needs the comparator power-on step
// RULE_17: power-fail conversion start to end equals the selected time
// RULE_18: converter stops in standby
// RULE_19: result read colliding with conversion end completes first
// RULE_20: mode or channel write colliding with conversion end wins
// RULE_21: power-fail enabled raises the end event only on compare hit
`timescale 1ns/100ps
`include "adcpf_defines.svh"
`default_nettype none

module adcpf_ctrl (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // avalon-mm slave
  input wire logic [4:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // analog core and system
  input wire logic [9:0] adc_data_in,
  input wire logic standby_in,
  output logic [1:0] channel_sel_out,
  output logic comparator_on_out,
  output logic conversion_end_irq_out
);

  adcpf_pkg::adcpf_state_t state_r;
  logic [7:0] converter_mode_reg;
  logic [1:0] channel_select_reg;
  logic [9:0] conversion_result_reg;
  logic [7:0] powerfail_mode_reg;
  logic [7:0] powerfail_threshold_reg;
  logic waitreq_r;
  logic wt_cnt_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic pend_r;
  logic [9:0] pend_data_r;
  logic hit_r;
  logic [15:0] cnt_r;
  logic [15:0] age_r;
  logic [31:0] rd_mux;
  logic [15:0] conv_cyc;
  logic [9:0] new_data;
  logic slow;
  logic wr_fx;
  logic wr_mode;
  logic wr_chsel;
  logic cfg_wr;
  logic rd_res_act;
  logic run;
  logic conv_end_raw;
  logic conv_done;
  logic [2:0] sel;

  localparam logic [15:0] START_CYC = 16'(`ADCPF_CYC(`ADCPF_START_DLY_NS));

  function automatic logic [15:0] cyc_of(input logic [2:0] s);
    case (s)
      3'h0: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_0));
      3'h1: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_1));
      3'h2: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_2));
      3'h3: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_3));
      3'h4: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_4));
      3'h5: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_5));
      3'h6: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_6));
      default: cyc_of = 16'(`ADCPF_CYC(`ADCPF_CONV_NS_7));
    endcase
  endfunction

  function automatic logic pf_hit(input logic [9:0] v, input logic lt,
                                  input logic [7:0] thr);
    pf_hit = lt ? (v[9:2] < thr) : (v[9:2] >= thr);
  endfunction

  // access decode
  assign sel = converter_mode_reg[`ADCPF_MODE_SEL_HI:`ADCPF_MODE_SEL_LO];
  assign conv_cyc = cyc_of(sel);
  assign slow = (write_in && (address_in == `ADCPF_OFS_MODE ||
                 address_in == `ADCPF_OFS_CHSEL ||
                 address_in == `ADCPF_OFS_PFMODE ||
                 address_in == `ADCPF_OFS_PFTHR)) ||
                (read_in && address_in == `ADCPF_OFS_RESULT);
  assign wr_fx = write_in && !waitreq_r && byteenable_in[0];
  assign wr_mode = wr_fx && address_in == `ADCPF_OFS_MODE;
  assign wr_chsel = wr_fx && address_in == `ADCPF_OFS_CHSEL;
  assign cfg_wr = wr_mode || wr_chsel;
  assign rd_res_act = read_in && address_in == `ADCPF_OFS_RESULT;
  assign run = converter_mode_reg[`ADCPF_MODE_EN_BIT] && !standby_in;
  assign conv_end_raw = state_r == adcpf_pkg::ADCPF_CONV && cnt_r == conv_cyc - 16'h1;
  assign conv_done = conv_end_raw && run && !cfg_wr; // RULE_20
  assign new_data = conv_done ? adc_data_in : pend_data_r;

  // readback mux, reserved bits read zero
  always_comb begin
    rd_mux = 32'h0;
    case (address_in)
      `ADCPF_OFS_MODE: rd_mux[7:0] = converter_mode_reg;
      `ADCPF_OFS_CHSEL: rd_mux[1:0] = channel_select_reg;
      `ADCPF_OFS_RESULT: rd_mux[9:0] = conversion_result_reg;
      `ADCPF_OFS_PFMODE: rd_mux[7:0] = powerfail_mode_reg;
      `ADCPF_OFS_PFTHR: rd_mux[7:0] = powerfail_threshold_reg;
      `ADCPF_OFS_STATUS: begin
        rd_mux[`ADCPF_ST_BUSY_BIT] = state_r == adcpf_pkg::ADCPF_CONV;
        rd_mux[`ADCPF_ST_PEND_BIT] = pend_r;
        rd_mux[`ADCPF_ST_HIT_BIT] = hit_r;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // bus handshake, slow accesses take one extra wait cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      waitreq_r <= 1'b1;
      wt_cnt_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (!waitreq_r) begin
      waitreq_r <= 1'b1;
      wt_cnt_r <= 1'b0;
    end else if (read_in || write_in) begin
      if (wt_cnt_r == slow) begin // RULE_02 RULE_04 RULE_07 RULE_08 RULE_09
        waitreq_r <= 1'b0;
        rdata_r <= rd_mux;
      end else begin
        wt_cnt_r <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      converter_mode_reg <= `ADCPF_RST_BYTE;
      channel_select_reg <= `ADCPF_RST_CHSEL;
      powerfail_mode_reg <= `ADCPF_RST_BYTE;
      powerfail_threshold_reg <= `ADCPF_RST_BYTE;
    end else if (wr_fx) begin
      case (address_in)
        `ADCPF_OFS_MODE: converter_mode_reg <= writedata_in[7:0];
        `ADCPF_OFS_CHSEL: channel_select_reg <= writedata_in[1:0];
        `ADCPF_OFS_PFMODE: powerfail_mode_reg <= writedata_in[7:0];
        `ADCPF_OFS_PFTHR: powerfail_threshold_reg <= writedata_in[7:0];
        default: channel_select_reg <= channel_select_reg;
      endcase
    end
  end

  // conversion sequencer, restarts on mode or channel write
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= adcpf_pkg::ADCPF_IDLE;
      cnt_r <= 16'h0;
    end else if (!run) begin // RULE_18
      state_r <= adcpf_pkg::ADCPF_IDLE;
      cnt_r <= 16'h0;
    end else if (cfg_wr || state_r == adcpf_pkg::ADCPF_IDLE) begin
      state_r <= adcpf_pkg::ADCPF_START;
      cnt_r <= 16'h0;
    end else begin
      case (state_r)
        adcpf_pkg::ADCPF_START: begin
          if (cnt_r == START_CYC - 16'h1) begin
            state_r <= adcpf_pkg::ADCPF_CONV;
            cnt_r <= 16'h0;
          end else begin
            cnt_r <= cnt_r + 16'h1;
          end
        end
        adcpf_pkg::ADCPF_CONV: begin
          cnt_r <= conv_end_raw ? 16'h0 : cnt_r + 16'h1; // RULE_13 RULE_17
        end
        default: state_r <= adcpf_pkg::ADCPF_IDLE;
      endcase
    end
  end

  // result store and end event; result reads hold off the store
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conversion_result_reg <= `ADCPF_RST_RESULT;
      pend_r <= 1'b0;
      pend_data_r <= `ADCPF_RST_RESULT;
      hit_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      if (conv_done && rd_res_act) begin // RULE_19
        pend_r <= 1'b1;
        pend_data_r <= adc_data_in;
      end else if (cfg_wr) begin
        pend_r <= 1'b0; // RULE_05
      end else if ((conv_done || pend_r) && !rd_res_act) begin
        conversion_result_reg <= new_data;
        pend_r <= 1'b0;
        hit_r <= pf_hit(new_data, powerfail_mode_reg[`ADCPF_PFM_LT_BIT],
                        powerfail_threshold_reg);
        irq_r <= !powerfail_mode_reg[`ADCPF_PFM_EN_BIT] ||
                 pf_hit(new_data, powerfail_mode_reg[`ADCPF_PFM_LT_BIT],
                        powerfail_threshold_reg); // RULE_21
      end
    end
  end

  // checking helper: cycles since conversion start
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      age_r <= 16'h0;
    end else if (state_r != adcpf_pkg::ADCPF_CONV || conv_end_raw || cfg_wr) begin
      age_r <= 16'h0;
    end else begin
      age_r <= age_r + 16'h1;
    end
  end

  assign readdata_out = rdata_r;
  assign waitrequest_out = waitreq_r;
  assign channel_sel_out = channel_select_reg;
  assign comparator_on_out = converter_mode_reg[`ADCPF_MODE_CMP_BIT];
  assign conversion_end_irq_out = irq_r;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence two_waits;
    $past(waitrequest_out, 1) && $past(waitrequest_out, 2) &&
    ($past(read_in, 2) || $past(write_in, 2)) &&
    $past(address_in, 2) == address_in;
  endsequence

  chk_mode_wr_wait: assert property ( // RULE_02
    (write_in && address_in == `ADCPF_OFS_MODE && !waitrequest_out) |-> two_waits)
    else $error("mode write without wait cycle");
  chk_chsel_wr_wait: assert property ( // RULE_04
    (write_in && address_in == `ADCPF_OFS_CHSEL && !waitrequest_out) |-> two_waits)
    else $error("channel write without wait cycle");
  chk_result_rd_wait: assert property ( // RULE_07
    (rd_res_act && !waitrequest_out) |-> two_waits)
    else $error("result read without wait cycle");
  chk_pfm_wr_wait: assert property ( // RULE_08
    (write_in && address_in == `ADCPF_OFS_PFMODE && !waitrequest_out) |-> two_waits)
    else $error("pf mode write without wait cycle");
  chk_pft_wr_wait: assert property ( // RULE_09
    (write_in && address_in == `ADCPF_OFS_PFTHR && !waitrequest_out) |-> two_waits)
    else $error("pf threshold write without wait cycle");
  chk_conv_time: assert property ( // RULE_13
    conv_done |-> age_r == conv_cyc - 16'h1)
    else $error("conversion time differs from select");
  chk_pf_conv_time: assert property ( // RULE_17
    (conv_done && powerfail_mode_reg[`ADCPF_PFM_EN_BIT]) |-> age_r == conv_cyc - 16'h1)
    else $error("pf conversion time differs from select");
  chk_standby_stop: assert property ( // RULE_18
    standby_in |=> state_r == adcpf_pkg::ADCPF_IDLE ##0 !irq_r || $past(pend_r))
    else $error("converter runs in standby");
  chk_read_first: assert property ( // RULE_19
    (conv_done && rd_res_act) |=> $stable(conversion_result_reg) && pend_r)
    else $error("result overwritten during read");
  chk_write_wins: assert property ( // RULE_20
    (conv_end_raw && cfg_wr) |=> !conversion_end_irq_out && !pend_r)
    else $error("end event despite config write");
  chk_pf_irq_cond: assert property ( // RULE_21
    (conversion_end_irq_out && $past(powerfail_mode_reg[`ADCPF_PFM_EN_BIT])) |-> hit_r)
    else $error("pf event without compare hit");
  chk_wait_one_cycle: assert property ( // RULE_02
    !waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  chk_cfg_drops_pend: assert property ( // RULE_05
    cfg_wr |=> !pend_r)
    else $error("pending result kept across config write");
  chk_write_restart: assert property ( // RULE_20
    (cfg_wr && run) |=> state_r == adcpf_pkg::ADCPF_START)
    else $error("config write did not restart conversion");
  chk_store_deferred: assert property ( // RULE_19
    (pend_r && rd_res_act) |=> $stable(conversion_result_reg))
    else $error("result stored while read in progress");

endmodule

`default_nettype wire

// file: adcpf_analog_model.sv
// converter core stand-in feeding the sampled value to the control
// assumes the comparator power bit and channel select of the control
`timescale 1ns/100ps
`default_nettype none

module adcpf_analog_model (
  // clock
  input wire logic clk_in,
  // control side
  input wire logic power_in,
  input wire logic [1:0] channel_in,
  input wire logic [9:0] level_in,
  // sampled value
  output logic [9:0] sample_out
);
  logic [9:0] settle_r;
  logic [9:0] junk_r;

  // settling count, 700 cycles of comparator power
  always_ff @(posedge clk_in) begin
    if (!power_in) begin
      settle_r <= 10'h000;
    end else if (settle_r != 10'h2bc) begin
      settle_r <= settle_r + 10'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!power_in) begin
      junk_r <= 10'h155;
    end else begin
      junk_r <= ~junk_r + 10'h003;
    end
  end

  // unsettled comparator gives a changing wrong value
  assign sample_out = (settle_r == 10'h2bc) ? level_in + {8'h00, channel_in} : junk_r;
endmodule

`default_nettype wire

// file: test_adc_control_power_fail_compare.sv
// testbench of the converter control: bus latency, conversion time, compare
// assumes the analog model stands in for the converter core
`timescale 1ns/100ps
`default_nettype none

module test_adc_control_power_fail_compare;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] address_in = 5'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [3:0] byteenable_in = 4'h1;
  logic [31:0] writedata_in = 32'h00000000;
  logic standby_in = 1'b0;
  logic [9:0] level = 10'h2a4;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic [9:0] adc_data_in;
  logic [1:0] channel_sel_out;
  logic comparator_on_out;
  logic conversion_end_irq_out;
  logic [31:0] q;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  int cyc[8] = '{700, 900, 1200, 1400, 1800, 2400, 2800, 3600};

  always #10 clk_sys_in = ~clk_sys_in;

  adcpf_ctrl dut_u (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .address_in(address_in),
    .read_in(read_in),
    .write_in(write_in),
    .byteenable_in(byteenable_in),
    .writedata_in(writedata_in),
    .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .adc_data_in(adc_data_in),
    .standby_in(standby_in),
    .channel_sel_out(channel_sel_out),
    .comparator_on_out(comparator_on_out),
    .conversion_end_irq_out(conversion_end_irq_out)
  );

  adcpf_analog_model model_u (
    .clk_in(clk_sys_in),
    .power_in(comparator_on_out),
    .channel_in(channel_sel_out),
    .level_in(level),
    .sample_out(adc_data_in)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // one bus access, latency counted in edges up to waitrequest low
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d, input int lat);
    int c;
    c = 0;
    @(posedge clk_sys_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= ~wr;
    do begin
      @(posedge clk_sys_in);
      c++;
    end while (waitrequest_out !== 1'b0 && c < 40);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    chk("latency", lat, c);
    if (c >= 40) begin
      close_out();
    end
  endtask

  // edges until the end event is sampled high, bounded
  task automatic wirq(input int lim);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (conversion_end_irq_out !== 1'b1 && n < lim);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    acc(1'b0, 5'h00, 32'h0, 2);
    chk("mode", 32'h0, q);
    acc(1'b0, 5'h08, 32'h0, 3);
    chk("result", 32'h0, q);
    chk("channel pin", 32'h0, channel_sel_out);
    acc(1'b1, 5'h04, 32'h02, 3);
    acc(1'b0, 5'h04, 32'h0, 2);
    chk("channel", 32'h2, q);
    chk("channel pin", 32'h2, channel_sel_out);
    acc(1'b1, 5'h0c, 32'h00, 3);
    acc(1'b1, 5'h10, 32'h80, 3);
    acc(1'b0, 5'h10, 32'h0, 2);
    chk("threshold", 32'h80, q);
    byteenable_in <= 4'h0;
    acc(1'b1, 5'h10, 32'h55, 3);
    byteenable_in <= 4'h1;
    acc(1'b0, 5'h10, 32'h0, 2);
    chk("masked write", 32'h80, q);
    acc(1'b1, 5'h14, 32'hff, 2);
    acc(1'b0, 5'h18, 32'h0, 2);
    chk("unmapped", 32'h0, q);
    acc(1'b1, 5'h00, 32'h01, 3);
    repeat (700) @(posedge clk_sys_in);
    chk("comparator", 32'h1, comparator_on_out);
    for (int s = 0; s < 8; s++) begin
      acc(1'b1, 5'h00, 32'h01, 3);
      acc(1'b1, 5'h00, 32'h81 | (s << 3), 3);
      wirq(4000);
      chk("first end", 32'h1, n < 4000);
      wirq(4000);
      chk("conversion time", cyc[s], n);
      acc(1'b0, 5'h08, 32'h0, 3);
      chk("result", 32'h2a6, q);
    end
    wirq(4000);
    repeat (3595) @(posedge clk_sys_in);
    acc(1'b1, 5'h00, 32'hb9, 3);
    wirq(60);
    chk("write wins", 32'd60, n);
    acc(1'b1, 5'h00, 32'h01, 3);
    acc(1'b1, 5'h0c, 32'hc0, 3);
    level <= 10'h3fc;
    acc(1'b1, 5'h00, 32'h81, 3);
    wirq(1600);
    chk("no hit end", 32'd1600, n);
    level <= 10'h010;
    wirq(800);
    chk("hit end", 32'h1, n < 800);
    level <= 10'h020;
    repeat (696) @(posedge clk_sys_in);
    acc(1'b0, 5'h08, 32'h0, 3);
    chk("read first", 32'h012, q);
    wirq(10);
    chk("deferred end", 32'd2, n);
    acc(1'b0, 5'h08, 32'h0, 3);
    chk("deferred result", 32'h022, q);
    acc(1'b0, 5'h14, 32'h0, 2);
    chk("status", 32'h5, q);
    standby_in <= 1'b1;
    wirq(1600);
    chk("standby end", 32'd1600, n);
    acc(1'b0, 5'h14, 32'h0, 2);
    chk("busy", 32'h0, q[0]);
    standby_in <= 1'b0;
    close_out();
  end
endmodule

`default_nettype wire
